// *** rtl/lls_pkg.sv ***
// Shared constants, carriers and decode functions for the serial settings register bank
package lls_pkg;

    // Bus address and byte field layout
    localparam logic [6:0] SLAVE_ADDR     = 7'h54;
    localparam int         RW_BIT         = 0;
    localparam int         SUB_MSB        = 7;
    localparam int         SUB_LSB        = 5;
    localparam int         CHAN_MSB       = 3;
    localparam int         SEL_MSB        = 7;
    localparam int         SEL_LSB        = 5;
    localparam int         CODE_MSB       = 4;

    // Register offsets in the sub-address field, regulator selects in the data byte select field
    localparam logic [2:0] SUB_REGULATOR  = 3'h1;
    localparam logic [2:0] SUB_LED        = 3'h2;
    localparam logic [2:0] SEL_FIRST      = 3'h0;
    localparam logic [2:0] SEL_SECOND     = 3'h1;

    // Reset values and code table anchors
    localparam logic [4:0] CODE_RESET     = 5'h00;
    localparam logic       ON_RESET       = 1'h0;
    localparam logic [4:0] SECOND_SPLIT   = 5'h0f;
    localparam int         FIRST_BASE_MV  = 1750;
    localparam int         SECOND_LOW_MV  = 1100;
    localparam int         SECOND_HIGH_MV = 2500;
    localparam int         STEP_MV        = 50;
    localparam int         LED_FULL_UA    = 25000;
    localparam int         LED_STEPS      = 32;

    // Framing counts
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
    localparam logic [1:0] LAST_BYTE      = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RECV = 4'b0010,
        ST_ACK  = 4'b0100,
        ST_WAIT = 4'b1000
    } lls_state_t;

    typedef struct packed {
        logic        on;
        logic [4:0]  code;
        logic [11:0] mv;
    } lls_reg_t;

    typedef struct packed {
        logic [3:0]  on;
        logic [4:0]  code;
        logic [14:0] ua;
    } lls_led_t;

    function automatic logic [11:0] lls_first_mv(input logic [4:0] code);
        lls_first_mv = 12'(FIRST_BASE_MV + STEP_MV * int'(code));
    endfunction : lls_first_mv

    function automatic logic [11:0] lls_second_mv(input logic [4:0] code);
        if (code < SECOND_SPLIT) begin
            lls_second_mv = 12'(SECOND_LOW_MV + STEP_MV * int'(code));
        end else begin
            lls_second_mv = 12'(SECOND_HIGH_MV + STEP_MV * int'(code - SECOND_SPLIT));
        end
    endfunction : lls_second_mv

    // Equal steps up to full scale, truncated to whole microamps
    function automatic logic [14:0] lls_led_ua(input logic [4:0] code);
        lls_led_ua = 15'(((int'(code) + 1) * LED_FULL_UA) / LED_STEPS);
    endfunction : lls_led_ua

    typedef struct packed {
        lls_state_t  st;
        logic        scl_q;
        logic        sda_q;
        logic [3:0]  bit_cnt;
        logic [1:0]  byte_idx;
        logic [7:0]  sub;
        logic        sda_oe;
        lls_reg_t    first;
        lls_reg_t    second;
        lls_led_t    led;
    } lls_core_t;

    localparam lls_core_t CORE_RESET = '{
        st:       ST_IDLE,
        scl_q:    1'h1,
        sda_q:    1'h1,
        bit_cnt:  4'h0,
        byte_idx: 2'h0,
        sub:      8'h00,
        sda_oe:   1'h0,
        first:    '{ON_RESET, CODE_RESET, lls_first_mv(CODE_RESET)},
        second:   '{ON_RESET, CODE_RESET, lls_second_mv(CODE_RESET)},
        led:      '{4'h0, CODE_RESET, lls_led_ua(CODE_RESET)}
    };

endpackage : lls_pkg

// *** rtl/lls_sync.sv ***
// Two-stage level synchroniser for pin inputs
`timescale 1ns/1ps
module lls_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    initial begin
        if (W < 1) $error("lls_sync: W must be at least 1");
    end

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } lls_sync_t;

    lls_sync_t r;
    lls_sync_t next_r;

    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '1;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule : lls_sync

// *** rtl/lls_link_shift.sv ***
// Serial-clock domain shifter that gathers data bits on each rising clock edge
`timescale 1ns/1ps
module lls_link_shift (
    input  wire logic       scl,
    input  wire logic       rst,
    input  wire logic       sda,
    output logic      [7:0] shift_byte
);
    typedef struct packed {
        logic [7:0] shift;
    } lls_shift_t;

    lls_shift_t r;
    lls_shift_t next_r;

    // Most significant bit arrives first
    always_comb begin
        next_r.shift = {r.shift[6:0], sda};
    end

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign shift_byte = r.shift;
endmodule : lls_link_shift

// *** rtl/lls_regs.sv ***
// Write-only two-wire slave holding regulator and LED settings
`timescale 1ns/1ps
//
// Contract
// [R1] Only slave address 7'h54 is answered, all other addresses are ignored.
// [R2] The master sends seven address bits and a direction bit after START.
// [R3] The block only receives and never puts register contents on the data line.
// [R4] The second byte selects the register that the third byte is written into.
// [R5] The third byte is stored into the register chosen by the second byte.
// [R6] Sub-address 001 selects the regulators, sub-address 010 the Led_current_setting.
// [R7] Regulator select 000 picks the first regulator and 001 the second.
// [R8] Each of the four channel bits turns its function off at 0 and on at 1.
// [R9] The low five bits of the third byte are a 32-step level code.
// [R10] First regulator runs from 1750 mV at code 0 to 3300 mV at code 1f in 50 mV steps.
// [R11] Second regulator: 1100..1800 mV for codes 0..0e, 2500..3300 mV for 0f..1f.
// [R12] LED current runs in 32 equal steps from about 0.8 mA to 25 mA.
// [R13] Enable pin low clears all settings, the master must write them again.
// [R14] The master never holds clock or data low for 200 us or more.
// [R15] Address and both following bytes of a valid write are acknowledged, reads are not.
// [R16] Settings change only on a complete data byte, broken transfers are dropped.
module lls_regs
    import lls_pkg::*;
(
    input  wire logic     REF_CLK,
    input  wire logic     RST,
    input  wire logic     SCL,
    input  wire logic     SDA_IN,
    output logic          SDA_OUT,
    output logic          SDA_OE,
    input  wire logic     CHIP_ENABLE_PIN,
    output lls_reg_t      FIRST_REGULATOR,
    output lls_reg_t      SECOND_REGULATOR,
    output lls_led_t      LED_SETTING
);
    lls_core_t  q;
    lls_core_t  d;
    logic [2:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       en_s;
    logic [7:0] link_byte;
    logic       start_evt;
    logic       stop_evt;
    logic       scl_rise;
    logic       scl_fall;
    logic       cap_evt;
    logic       addr_ok;
    logic       sub_ok;

    lls_sync #(.W(3)) u_sync (
        .clk (REF_CLK),
        .rst (RST),
        .d   ({SCL, SDA_IN, CHIP_ENABLE_PIN}),
        .q   (pins_s)
    );

    // Byte bits gathered on the link clock; read only while the byte is held stable
    lls_link_shift u_shift (
        .scl        (SCL),
        .rst        (RST),
        .sda        (SDA_IN),
        .shift_byte (link_byte)
    );

    assign scl_s = pins_s[2];
    assign sda_s = pins_s[1];
    assign en_s  = pins_s[0];

    assign start_evt = scl_s && q.scl_q && q.sda_q && !sda_s;
    assign stop_evt  = scl_s && q.scl_q && !q.sda_q && sda_s;
    assign scl_rise  = scl_s && !q.scl_q;
    assign scl_fall  = !scl_s && q.scl_q;
    assign cap_evt   = (q.st == ST_RECV) && (q.bit_cnt == BITS_PER_BYTE) && scl_fall;
    assign addr_ok   = (link_byte[7:1] == SLAVE_ADDR) && !link_byte[RW_BIT];      // [R1]
    assign sub_ok    = (link_byte[SUB_MSB:SUB_LSB] == SUB_REGULATOR)
                    || (link_byte[SUB_MSB:SUB_LSB] == SUB_LED);                   // [R6]

    always_comb begin
        d       = q;
        d.scl_q = scl_s;
        d.sda_q = sda_s;
        if (!en_s) begin
            d       = CORE_RESET;                                                 // [R13]
            d.scl_q = scl_s;
            d.sda_q = sda_s;
        end else if (start_evt) begin
            d.st       = ST_RECV;                                                 // [R2]
            d.bit_cnt  = 4'h0;
            d.byte_idx = 2'h0;
            d.sda_oe   = 1'b0;                                                    // [R16]
        end else if (stop_evt) begin
            d.st     = ST_IDLE;                                                   // [R16]
            d.sda_oe = 1'b0;
        end else begin
            case (q.st)
                ST_IDLE: begin
                    d.st = ST_IDLE;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (cap_evt) begin
                        d.st = ST_WAIT;
                        case (q.byte_idx)
                            2'h0: begin
                                if (addr_ok) begin
                                    d.st     = ST_ACK;                            // [R15]
                                    d.sda_oe = 1'b1;
                                end
                            end
                            2'h1: begin
                                if (sub_ok) begin
                                    d.sub    = link_byte;                         // [R4]
                                    d.st     = ST_ACK;
                                    d.sda_oe = 1'b1;
                                end
                            end
                            default: begin
                                d.st     = ST_ACK;                                // [R15]
                                d.sda_oe = 1'b1;
                                if (q.sub[SUB_MSB:SUB_LSB] == SUB_LED) begin
                                    d.led.on   = q.sub[CHAN_MSB:0];               // [R8]
                                    d.led.code = link_byte[CODE_MSB:0];           // [R5]
                                    d.led.ua   = lls_led_ua(link_byte[CODE_MSB:0]); // [R12]
                                end else begin
                                    d.first.on  = q.sub[0];                       // [R8]
                                    d.second.on = q.sub[1];
                                    if (link_byte[SEL_MSB:SEL_LSB] == SEL_FIRST) begin
                                        d.first.code = link_byte[CODE_MSB:0];     // [R7]
                                        d.first.mv   = lls_first_mv(link_byte[CODE_MSB:0]); // [R10]
                                    end else if (link_byte[SEL_MSB:SEL_LSB] == SEL_SECOND) begin
                                        d.second.code = link_byte[CODE_MSB:0];    // [R9]
                                        d.second.mv = lls_second_mv(link_byte[CODE_MSB:0]); // [R11]
                                    end
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        d.sda_oe = 1'b0;
                        if (q.byte_idx == LAST_BYTE) begin
                            d.st = ST_WAIT;
                        end else begin
                            d.st       = ST_RECV;
                            d.bit_cnt  = 4'h0;
                            d.byte_idx = q.byte_idx + 2'h1;
                        end
                    end
                end
                ST_WAIT: begin
                    d.st = ST_WAIT;
                end
                default: begin
                    d.st     = ST_IDLE;
                    d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            q <= CORE_RESET;
        end else begin
            q <= d;
        end
    end

    // The line is only ever pulled low, never driven high
    assign SDA_OUT          = 1'b0;                                               // [R3]
    assign SDA_OE           = q.sda_oe;
    assign FIRST_REGULATOR  = q.first;
    assign SECOND_REGULATOR = q.second;
    assign LED_SETTING      = q.led;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    sequence s_byte_taken(logic [1:0] idx);
        cap_evt && en_s && !start_evt && !stop_evt && q.byte_idx == idx;
    endsequence

    property p_foreign_addr;
        s_byte_taken(2'h0) ##0 (link_byte[7:1] != SLAVE_ADDR) |=>
            (q.st == ST_WAIT && !q.sda_oe) [*2];
    endproperty
    a_foreign_addr: assert property (p_foreign_addr)                              // [R1]
        else $error("foreign address was answered");

    property p_read_nack;
        s_byte_taken(2'h0) ##0 link_byte[RW_BIT] |=> !q.sda_oe;
    endproperty
    a_read_nack: assert property (p_read_nack)                                    // [R15]
        else $error("read request was acknowledged");

    property p_drive_only_ack;
        q.sda_oe |-> q.st == ST_ACK;
    endproperty
    a_drive_only_ack: assert property (p_drive_only_ack)                          // [R3]
        else $error("data line driven outside an acknowledge");

    property p_ack_write;
        s_byte_taken(2'h0) ##0 addr_ok |=> q.sda_oe && q.st == ST_ACK;
    endproperty
    a_ack_write: assert property (p_ack_write)                                    // [R15]
        else $error("valid write address not acknowledged");

    property p_bad_sub;
        s_byte_taken(2'h1) ##0 !sub_ok |=> q.st == ST_WAIT && !q.sda_oe;
    endproperty
    a_bad_sub: assert property (p_bad_sub)                                        // [R6]
        else $error("unknown sub-address was acknowledged");

    property p_led_store;
        s_byte_taken(2'h2) ##0 (q.sub[SUB_MSB:SUB_LSB] == SUB_LED) |=>
            q.led.code == $past(link_byte[CODE_MSB:0]) && q.led.on == $past(q.sub[CHAN_MSB:0]);
    endproperty
    a_led_store: assert property (p_led_store)                                    // [R5]
        else $error("LED setting not stored from data byte");

    property p_first_volts;
        q.first.mv == 12'(FIRST_BASE_MV + STEP_MV * int'(q.first.code));
    endproperty
    a_first_volts: assert property (p_first_volts)                                // [R10]
        else $error("first regulator voltage does not match its code");

    property p_second_volts;
        (q.second.code == 5'h0e |-> q.second.mv == 12'd1800)
        and (q.second.code == 5'h0f |-> q.second.mv == 12'd2500);
    endproperty
    a_second_volts: assert property (p_second_volts)                              // [R11]
        else $error("second regulator voltage split is wrong");

    property p_enable_clears;
        !en_s |=> q.first == CORE_RESET.first && q.second == CORE_RESET.second
                  && q.led == CORE_RESET.led && !q.sda_oe;
    endproperty
    a_enable_clears: assert property (p_enable_clears)                            // [R13]
        else $error("settings survive enable low");

    property p_no_partial;
        en_s && !cap_evt |=> $stable(q.led) && $stable(q.first.code) && $stable(q.second.code);
    endproperty
    a_no_partial: assert property (p_no_partial)                                  // [R16]
        else $error("settings changed without a complete data byte");

    // Regulator data byte, split by its select field
    sequence s_regulator_data;
        s_byte_taken(2'h2) ##0 (q.sub[SUB_MSB:SUB_LSB] == SUB_REGULATOR);
    endsequence

    property p_first_store;
        s_regulator_data ##0 (link_byte[SEL_MSB:SEL_LSB] == SEL_FIRST) |=>
            q.first.code == $past(link_byte[CODE_MSB:0]) && q.first.on == $past(q.sub[0]);
    endproperty
    a_first_store: assert property (p_first_store)                                // [R7]
        else $error("first regulator not stored from data byte");

    property p_second_store;
        s_regulator_data ##0 (link_byte[SEL_MSB:SEL_LSB] == SEL_SECOND) |=>
            q.second.code == $past(link_byte[CODE_MSB:0]) && q.second.on == $past(q.sub[1]);
    endproperty
    a_second_store: assert property (p_second_store)                              // [R7]
        else $error("second regulator not stored from data byte");

    property p_bad_select;
        s_regulator_data ##0 (link_byte[SEL_MSB:SEL_LSB] != SEL_FIRST)
            ##0 (link_byte[SEL_MSB:SEL_LSB] != SEL_SECOND) |=>
            $stable(q.first.code) && $stable(q.second.code);
    endproperty
    a_bad_select: assert property (p_bad_select)                                  // [R7]
        else $error("unknown regulator select changed a level code");

    property p_sub_ack;
        s_byte_taken(2'h1) ##0 sub_ok |=> q.sda_oe && q.st == ST_ACK;
    endproperty
    a_sub_ack: assert property (p_sub_ack)                                        // [R6]
        else $error("known sub-address not acknowledged");

    property p_data_ack;
        s_byte_taken(2'h2) |=> q.sda_oe && q.st == ST_ACK;
    endproperty
    a_data_ack: assert property (p_data_ack)                                      // [R15]
        else $error("data byte not acknowledged");

    property p_ack_release;
        q.st == ST_ACK && scl_fall && en_s && !start_evt && !stop_evt |=> !q.sda_oe;
    endproperty
    a_ack_release: assert property (p_ack_release)                                // [R15]
        else $error("data line held after the acknowledge clock");

    property p_start_restarts;
        start_evt && en_s |=> q.st == ST_RECV && q.bit_cnt == 4'h0 && q.byte_idx == 2'h0;
    endproperty
    a_start_restarts: assert property (p_start_restarts)                          // [R16]
        else $error("start condition did not restart reception");

    property p_stop_idles;
        stop_evt && en_s && !start_evt |=> q.st == ST_IDLE && !q.sda_oe;
    endproperty
    a_stop_idles: assert property (p_stop_idles)                                  // [R16]
        else $error("stop condition did not end the transfer");

    property p_led_full;
        q.led.code == 5'h1f |-> q.led.ua == 15'd25000;
    endproperty
    a_led_full: assert property (p_led_full)                                      // [R12]
        else $error("LED full-scale current wrong");

endmodule : lls_regs

// *** dv/lls_host.sv ***
// Host bus master model that writes the settings over the two-wire bus
`timescale 1ns/1ps
module lls_host (
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // Four reference cycles per phase keeps every low phase far below the stall limit
    task automatic half();
        repeat (4) @(negedge ref_clk);
    endtask : half

    // Works from idle and as a repeated start with the clock low
    task automatic start();
        sda_drv = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b0;
        half();
        scl = 1'b0;
        half();
    endtask : start

    task automatic stop();
        sda_drv = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_drv = 1'b1;
        half();
    endtask : stop

    // Sends the top n bits MSB first; a full byte is followed by the ack clock
    task automatic send(input logic [7:0] b, input int n, output logic ack);
        ack = 1'b0;
        for (int i = 0; i < n; i++) begin
            sda_drv = b[7-i];
            half();
            scl = 1'b1;
            half();
            scl = 1'b0;
            half();
        end
        if (n == 8) begin
            sda_drv = 1'b1;
            half();
            scl = 1'b1;
            half();
            ack = (sda === 1'b0);
            scl = 1'b0;
            half();
        end
    endtask : send
endmodule : lls_host

// *** dv/tb_top.sv ***
// Self-checking bench for the serial settings register bank
`timescale 1ns/1ps
module tb_top;
    import lls_pkg::*;

    logic     ref_clk = 1'b0;
    logic     rst     = 1'b1;
    logic     chip_en = 1'b1;
    logic     scl;
    logic     host_sda;
    logic     sda;
    logic     sda_out;
    logic     sda_oe;
    lls_reg_t first_reg;
    lls_reg_t second_reg;
    lls_led_t led;
    int       n_mismatch = 0;
    int       num_checks = 0;
    int       cycles     = 0;

    always #5 ref_clk = ~ref_clk;

    // Open-drain wire with pull-up
    assign sda = (sda_oe ? sda_out : 1'b1) & host_sda;

    lls_regs lls_regs_inst (
        .REF_CLK          (ref_clk),
        .RST              (rst),
        .SCL              (scl),
        .SDA_IN           (sda),
        .SDA_OUT          (sda_out),
        .SDA_OE           (sda_oe),
        .CHIP_ENABLE_PIN  (chip_en),
        .FIRST_REGULATOR  (first_reg),
        .SECOND_REGULATOR (second_reg),
        .LED_SETTING      (led)
    );

    lls_host lls_host_inst (
        .ref_clk (ref_clk),
        .sda     (sda),
        .scl     (scl),
        .sda_drv (host_sda)
    );

    task automatic finish_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic xfer(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d,
                        input logic [2:0] exp_ack);
        logic [7:0] b [3];
        logic       ack;
        b = '{a, s, d};
        lls_host_inst.start();
        for (int i = 0; i < 3; i++) begin
            lls_host_inst.send(b[i], 8, ack);
            chk(32'(ack), 32'(exp_ack[2-i]));
        end
        lls_host_inst.stop();
    endtask : xfer

    function automatic lls_reg_t first_exp(input logic on, input logic [4:0] c);
        first_exp = '{on, c, 12'(FIRST_BASE_MV + STEP_MV * int'(c))};
    endfunction : first_exp

    function automatic lls_led_t led_exp(input logic [3:0] on, input logic [4:0] c);
        led_exp = '{on, c, 15'(((int'(c) + 1) * 25000) / 32)};
    endfunction : led_exp

    task automatic chk_cleared();
        chk(32'(first_reg), 32'(first_exp(1'b0, 5'h00)));
        chk(32'(second_reg), 32'({1'b0, 5'h00, 12'd1100}));
        chk(32'(led), 32'(led_exp(4'h0, 5'h00)));
    endtask : chk_cleared

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        logic ack;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk_cleared();
        xfer(8'ha8, 8'h4f, 8'h1f, 3'b111);
        chk(32'(led), 32'({4'hf, 5'h1f, 15'd25000}));
        xfer(8'ha8, 8'h45, 8'he0, 3'b111);
        chk(32'(led), 32'(led_exp(4'h5, 5'h00)));
        xfer(8'ha8, 8'h21, 8'h1f, 3'b111);
        chk(32'(first_reg), 32'({1'b1, 5'h1f, 12'd3300}));
        chk(32'(second_reg), 32'({1'b0, 5'h00, 12'd1100}));
        xfer(8'ha8, 8'h23, 8'h2e, 3'b111);
        chk(32'(second_reg), 32'({1'b1, 5'h0e, 12'd1800}));
        chk(32'(first_reg), 32'({1'b1, 5'h1f, 12'd3300}));
        xfer(8'ha8, 8'h22, 8'h2f, 3'b111);
        chk(32'(second_reg), 32'({1'b1, 5'h0f, 12'd2500}));
        chk(32'(first_reg), 32'({1'b0, 5'h1f, 12'd3300}));
        // Unknown regulator select applies the enables but keeps both codes
        xfer(8'ha8, 8'h23, 8'h4a, 3'b111);
        chk(32'(first_reg), 32'({1'b1, 5'h1f, 12'd3300}));
        chk(32'(second_reg), 32'({1'b1, 5'h0f, 12'd2500}));
        xfer(8'ha8, 8'h22, 8'h2f, 3'b111);
        // Foreign address, read request and unknown sub-address leave settings alone
        xfer(8'haa, 8'h4f, 8'h1f, 3'b000);
        xfer(8'ha9, 8'h4f, 8'h1f, 3'b000);
        xfer(8'ha8, 8'h6f, 8'h1f, 3'b100);
        chk(32'(led), 32'(led_exp(4'h5, 5'h00)));
        // Data byte cut off after four bits, ended by repeated start and then by stop
        lls_host_inst.start();
        lls_host_inst.send(8'ha8, 8, ack);
        lls_host_inst.send(8'h4a, 8, ack);
        lls_host_inst.send(8'hff, 4, ack);
        lls_host_inst.start();
        lls_host_inst.send(8'ha8, 8, ack);
        lls_host_inst.send(8'h4a, 8, ack);
        lls_host_inst.send(8'hff, 4, ack);
        lls_host_inst.stop();
        repeat (8) @(negedge ref_clk);
        chk(32'(led), 32'(led_exp(4'h5, 5'h00)));
        chk(32'(second_reg), 32'({1'b1, 5'h0f, 12'd2500}));
        chip_en = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk_cleared();
        xfer(8'ha8, 8'h4f, 8'h1f, 3'b000);
        chk(32'(led), 32'(led_exp(4'h0, 5'h00)));
        chip_en = 1'b1;
        repeat (8) @(negedge ref_clk);
        // Host writes a new LED setting once the enable pin is back
        xfer(8'ha8, 8'h43, 8'h10, 3'b111);
        chk(32'(led), 32'(led_exp(4'h3, 5'h10)));
        finish_test();
    end
endmodule : tb_top
